// ===== include/fchb_defines.vh
// constants for the flash card host bus controller
`ifndef FCHB_DEFINES_VH
`define FCHB_DEFINES_VH
`define FCHB_ADDR_W 25
`define FCHB_DATA_W 16
`define FCHB_LANE_W 8
`define FCHB_T_ACC_NS 150
`define FCHB_T_SETUP_NS 40
`define FCHB_T_WP_NS 100
`define FCHB_T_HOLD_NS 40
`define FCHB_T_RST_NS 500
`define FCHB_CLK_NS 20
`define FCHB_ACC_CYC ((`FCHB_T_ACC_NS + `FCHB_CLK_NS - 1) / `FCHB_CLK_NS)
`define FCHB_SETUP_CYC ((`FCHB_T_SETUP_NS + `FCHB_CLK_NS - 1) / `FCHB_CLK_NS)
`define FCHB_WP_CYC ((`FCHB_T_WP_NS + `FCHB_CLK_NS - 1) / `FCHB_CLK_NS)
`define FCHB_HOLD_CYC ((`FCHB_T_HOLD_NS + `FCHB_CLK_NS - 1) / `FCHB_CLK_NS)
`define FCHB_RST_CYC ((`FCHB_T_RST_NS + `FCHB_CLK_NS - 1) / `FCHB_CLK_NS)
`define FCHB_SECTOR_SHIFT 15
`define FCHB_DEV2_SHIFT 19
`define FCHB_DEV4_SHIFT 20
`endif

// ===== rtl/fchb_lane_decode.v
// lane select decoder from host address bit zero and byte/word mode
module fchb_lane_decode (
   hostAddr0, // host byte address bit zero
   byteMode, // high: byte access
   lowLaneSelect_n, // low lane select, active low
   highLaneSelect_n // high lane select, active low
);
   input wire hostAddr0;
   input wire byteMode;
   output wire lowLaneSelect_n;
   output wire highLaneSelect_n;

   // word: both lanes; byte: even byte on low lane, odd on high lane
   assign lowLaneSelect_n = byteMode & hostAddr0;
   assign highLaneSelect_n = byteMode & ~hostAddr0;
endmodule

// ===== rtl/fchb_host.v
// host controller driving the flash card bus pins
// Operation
// - read strobe low, data valid after access
// - narrow host flag ignored, use high lane
// - voltage sense open means five volt card
// - lane selects decoded from bit zero, mode
// - only listed select/strobe combinations used
// - multi device-pair erase needs more current
// - host leaves erase-affected addresses to software
`include "fchb_defines.vh"
module fchb_host #(
   parameter ADDR_W = `FCHB_ADDR_W, // card word address width
   parameter DATA_W = `FCHB_DATA_W, // data bus width
   parameter ACC_CYC = `FCHB_ACC_CYC, // read strobe low cycles
   parameter SETUP_CYC = `FCHB_SETUP_CYC, // address setup cycles
   parameter WP_CYC = `FCHB_WP_CYC, // write strobe low cycles
   parameter HOLD_CYC = `FCHB_HOLD_CYC, // hold after strobe rise
   parameter RST_CYC = `FCHB_RST_CYC // card reset low cycles
) (
   clk, // system clock
   sys_rst, // synchronous reset, active high
   reqValid, // request strobe
   reqReady, // controller idle
   reqWrite, // high: write, low: read
   reqByte, // high: byte access
   reqAddr, // host byte address
   reqWdata, // write data, byte in its own lane
   reqCardReset, // request card reset pulse
   rspValid, // one-cycle completion pulse
   rspRdata, // read data
   cardPresent, // seated detect low and early insert seen
   cardEarly, // early insert seen
   card5V, // both voltage sense open
   cardReady, // card not busy
   cardAddr, // card word address pins
   outEnable_n, // read strobe
   writeEnable_n, // write strobe
   low_lane_select_n, // low lane select
   high_lane_select_n, // high lane select
   cardReset_n, // card reset pin
   narrow_host_flag_n, // bus size flag, held high
   dataIn, // data pins in
   dataOut, // data pins out
   dataOe, // per-lane drive enables
   flash_ready_busy_n, // card busy pin
   seated_detect_n, // seated detect pin
   early_insert_detect_n, // early insert pin
   voltage_sense_first_n, // voltage sense 1
   voltage_sense_second_n // voltage sense 2
);
   input wire clk;
   input wire sys_rst;
   input wire reqValid;
   output wire reqReady;
   input wire reqWrite;
   input wire reqByte;
   input wire [ADDR_W:0] reqAddr;
   input wire [DATA_W-1:0] reqWdata;
   input wire reqCardReset;
   output wire rspValid;
   output wire [DATA_W-1:0] rspRdata;
   output wire cardPresent;
   output wire cardEarly;
   output wire card5V;
   output wire cardReady;
   output wire [ADDR_W-1:0] cardAddr;
   output wire outEnable_n;
   output wire writeEnable_n;
   output wire low_lane_select_n;
   output wire high_lane_select_n;
   output wire cardReset_n;
   output wire narrow_host_flag_n;
   input wire [DATA_W-1:0] dataIn;
   output wire [DATA_W-1:0] dataOut;
   output wire [1:0] dataOe;
   input wire flash_ready_busy_n;
   input wire seated_detect_n;
   input wire early_insert_detect_n;
   input wire voltage_sense_first_n;
   input wire voltage_sense_second_n;

   localparam [2:0] ST_IDLE = 3'H0;
   localparam [2:0] ST_SETUP = 3'H1;
   localparam [2:0] ST_STROBE = 3'H2;
   localparam [2:0] ST_HOLD = 3'H3;
   localparam [2:0] ST_RESET = 3'H4;
   localparam [2:0] ST_DONE = 3'H5;

   reg [2:0] state_ff, nxt_state;
   reg [15:0] cnt_ff, nxt_cnt;
   reg write_ff, nxt_write;
   reg [ADDR_W-1:0] addr_ff, nxt_addr;
   reg [DATA_W-1:0] wdata_ff, nxt_wdata;
   reg [DATA_W-1:0] rdata_ff, nxt_rdata;
   reg selByte_ff, nxt_selByte;
   reg selOdd_ff, nxt_selOdd;
   reg oe_ff, nxt_oe;
   reg we_ff, nxt_we;
   reg drive_ff, nxt_drive;
   reg rst_ff, nxt_rst;
   reg done_ff, nxt_done;
   reg early_ff;
   reg [3:0] pinSample_ff;
   wire decLow_n;
   wire decHigh_n;

   fchb_lane_decode u_dec (
      .hostAddr0(selOdd_ff),
      .byteMode(selByte_ff),
      .lowLaneSelect_n(decLow_n),
      .highLaneSelect_n(decHigh_n)
   );

   // selects held inactive outside a cycle so lanes stay floated
   wire active = (state_ff == ST_SETUP) | (state_ff == ST_STROBE) | (state_ff == ST_HOLD);
   assign low_lane_select_n = active ? decLow_n : 1'B1;
   assign high_lane_select_n = active ? decHigh_n : 1'B1;
   assign outEnable_n = ~oe_ff;
   assign writeEnable_n = ~we_ff;
   assign cardReset_n = ~rst_ff;
   assign narrow_host_flag_n = 1'B1;
   assign cardAddr = addr_ff;
   assign dataOut = wdata_ff;
   // drive only the selected lanes, and never while read strobe low
   assign dataOe = {drive_ff & ~decHigh_n, drive_ff & ~decLow_n};
   assign reqReady = (state_ff == ST_IDLE);
   assign rspValid = done_ff;
   assign rspRdata = rdata_ff;
   assign cardPresent = ~pinSample_ff[0] & early_ff;
   assign cardEarly = early_ff;
   assign card5V = pinSample_ff[2] & pinSample_ff[3];
   assign cardReady = pinSample_ff[1];

   always @(posedge clk) begin
      if (sys_rst) begin
         pinSample_ff <= 4'H0;
         early_ff <= 1'B0;
      end else begin
         pinSample_ff <= {voltage_sense_second_n, voltage_sense_first_n,
            flash_ready_busy_n, seated_detect_n};
         // early contact latches until card leaves entirely
         early_ff <= ~early_insert_detect_n | (early_ff & ~seated_detect_n);
      end
   end

   always @* begin
      nxt_state = state_ff;
      nxt_cnt = cnt_ff;
      nxt_write = write_ff;
      nxt_addr = addr_ff;
      nxt_wdata = wdata_ff;
      nxt_rdata = rdata_ff;
      nxt_selByte = selByte_ff;
      nxt_selOdd = selOdd_ff;
      nxt_oe = oe_ff;
      nxt_we = we_ff;
      nxt_drive = drive_ff;
      nxt_rst = rst_ff;
      nxt_done = 1'B0;
      case (state_ff)
         ST_IDLE: begin
            // erase scope and supply budget stay with software
            if (reqCardReset) begin
               nxt_rst = 1'B1;
               nxt_cnt = RST_CYC[15:0];
               nxt_state = ST_RESET;
            end else if (reqValid) begin
               nxt_addr = reqAddr[ADDR_W:1];
               nxt_selOdd = reqAddr[0];
               nxt_selByte = reqByte;
               nxt_write = reqWrite;
               nxt_wdata = reqWdata;
               nxt_cnt = SETUP_CYC[15:0];
               nxt_state = ST_SETUP;
            end
         end
         ST_SETUP: begin
            // address settles before either strobe falls
            if (cnt_ff <= 16'H0001) begin
               if (write_ff) begin
                  nxt_we = 1'B1;
                  nxt_drive = 1'B1;
                  nxt_cnt = WP_CYC[15:0];
               end else begin
                  nxt_oe = 1'B1;
                  nxt_cnt = ACC_CYC[15:0];
               end
               nxt_state = ST_STROBE;
            end else begin
               nxt_cnt = cnt_ff - 16'H0001;
            end
         end
         ST_STROBE: begin
            if (cnt_ff <= 16'H0001) begin
               if (write_ff) begin
                  nxt_we = 1'B0;
               end else begin
                  // each byte kept on its own lane
                  nxt_rdata = dataIn;
                  nxt_oe = 1'B0;
               end
               nxt_cnt = HOLD_CYC[15:0];
               nxt_state = ST_HOLD;
            end else begin
               nxt_cnt = cnt_ff - 16'H0001;
            end
         end
         ST_HOLD: begin
            // data held past write strobe rise for capture
            if (cnt_ff <= 16'H0001) begin
               nxt_drive = 1'B0;
               nxt_state = ST_DONE;
            end else begin
               nxt_cnt = cnt_ff - 16'H0001;
            end
         end
         ST_RESET: begin
            if (cnt_ff <= 16'H0001) begin
               nxt_rst = 1'B0;
               nxt_state = ST_DONE;
            end else begin
               nxt_cnt = cnt_ff - 16'H0001;
            end
         end
         ST_DONE: begin
            nxt_done = 1'B1;
            nxt_state = ST_IDLE;
         end
         default: begin
            nxt_state = ST_IDLE;
         end
      endcase
   end

   always @(posedge clk) begin
      if (sys_rst) begin
         state_ff <= ST_IDLE;
         cnt_ff <= 16'H0000;
         write_ff <= 1'B0;
         addr_ff <= {ADDR_W{1'B0}};
         wdata_ff <= {DATA_W{1'B0}};
         rdata_ff <= {DATA_W{1'B0}};
         selByte_ff <= 1'B0;
         selOdd_ff <= 1'B0;
         oe_ff <= 1'B0;
         we_ff <= 1'B0;
         drive_ff <= 1'B0;
         rst_ff <= 1'B0;
         done_ff <= 1'B0;
      end else begin
         state_ff <= nxt_state;
         cnt_ff <= nxt_cnt;
         write_ff <= nxt_write;
         addr_ff <= nxt_addr;
         wdata_ff <= nxt_wdata;
         rdata_ff <= nxt_rdata;
         selByte_ff <= nxt_selByte;
         selOdd_ff <= nxt_selOdd;
         oe_ff <= nxt_oe;
         we_ff <= nxt_we;
         drive_ff <= nxt_drive;
         rst_ff <= nxt_rst;
         done_ff <= nxt_done;
      end
   end
endmodule

// ===== tb/fchb_host_properties.sv
// port-level checks of the flash card host controller
module fchb_host_props (
   input wire clk, sys_rst, reqValid, reqReady, reqWrite, reqByte, reqCardReset,
   input wire [25:0] reqAddr,
   input wire [24:0] cardAddr,
   input wire rspValid, outEnable_n, writeEnable_n, cardReset_n, cardReady,
   input wire low_lane_select_n, high_lane_select_n, flash_ready_busy_n,
   input wire [1:0] dataOe
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);
   wire go = reqValid && reqReady && !reqCardReset;
   AST_ADDR: assert property (go |=> ##1 cardAddr == $past(reqAddr[25:1], 2))
      else $error("card address wrong");
   AST_WSEL: assert property (go && !reqByte |=> ##1
      !low_lane_select_n && !high_lane_select_n) else $error("word lanes wrong");
   AST_BSEL: assert property (go && reqByte |=> ##1
      low_lane_select_n == $past(reqAddr[0], 2) && high_lane_select_n != $past(reqAddr[0], 2))
      else $error("byte lane wrong");
   AST_RD: assert property (go && !reqWrite |-> ##[2:5] $fell(outEnable_n) ##0
      !outEnable_n[*8] ##1 outEnable_n) else $error("read strobe length wrong");
   AST_WR: assert property (go && reqWrite |-> ##[2:5] $fell(writeEnable_n) ##0
      !writeEnable_n[*5] ##1 writeEnable_n) else $error("write strobe length wrong");
   AST_EXCL: assert property (!outEnable_n |-> writeEnable_n)
      else $error("both strobes low");
   AST_SEL: assert property ((!outEnable_n || !writeEnable_n) |->
      !(low_lane_select_n && high_lane_select_n)) else $error("strobe without lane");
   AST_FLOAT: assert property (!outEnable_n |-> dataOe == 2'H0)
      else $error("host drives during read");
   AST_WLANE: assert property (!writeEnable_n |->
      dataOe == {!high_lane_select_n, !low_lane_select_n})
      else $error("write lane drive wrong");
   // bench runs with a two-cycle card reset pulse
   AST_RST: assert property (reqCardReset && reqReady |-> ##[1:3] $fell(cardReset_n) ##0
      !cardReset_n[*2] ##1 cardReset_n) else $error("card reset pulse wrong");
   AST_BUSY: assert property ($fell(flash_ready_busy_n) |-> ##[1:3] !cardReady)
      else $error("busy not seen");
   cover property (go && reqWrite);
   cover property (go && reqByte && !reqWrite);
   cover property (reqCardReset && reqReady);
endmodule

bind fchb_host fchb_host_props u_props (.clk, .sys_rst, .reqValid, .reqReady, .reqWrite,
   .reqByte, .reqCardReset, .reqAddr, .cardAddr, .rspValid, .outEnable_n, .writeEnable_n,
   .cardReset_n, .cardReady, .low_lane_select_n, .high_lane_select_n, .flash_ready_busy_n,
   .dataOe);

// ===== tb/fchb_card_model.sv
// behavioural flash card on the far side of the host pins
module fchb_card_model #(
   parameter T_OE = 120 // output enable access, ns
) (
   input wire ins, busy, cardReset_n, outEnable_n, writeEnable_n,
   input wire low_lane_select_n, high_lane_select_n,
   input wire [24:0] cardAddr,
   input wire [15:0] dataOut,
   input wire [1:0] dataOe,
   output wire [15:0] dataIn,
   output wire flash_ready_busy_n, seated_detect_n, early_insert_detect_n,
   output wire voltage_sense_first_n, voltage_sense_second_n
);
   timeunit 1ns;
   timeprecision 1ns;
   reg [15:0] mem [0:15];
   reg [15:0] lastV = 16'H0;
   reg [3:0] wa = 4'H0;
   reg rdMode = 1'b1;
   integer i;
   initial for (i = 0; i < 16; i = i + 1) mem[i] = 16'HFFFF; // erased array
   // upper lines undecoded, so the space repeats; narrow host flag unused
   always @(negedge writeEnable_n) wa = cardAddr[3:0];
   always @(posedge writeEnable_n) begin
      if (!low_lane_select_n) mem[wa][7:0] = mem[wa][7:0] & dataOut[7:0];
      if (!high_lane_select_n) mem[wa][15:8] = mem[wa][15:8] & dataOut[15:8];
   end
   // reads only work again once the reset pin has risen
   always @(negedge cardReset_n) rdMode = 1'b0;
   always @(posedge cardReset_n) rdMode = 1'b1;
   wire rd = rdMode && !outEnable_n && writeEnable_n;
   wire #(T_OE, 0) okL = rd && !low_lane_select_n;
   wire #(T_OE, 0) okH = rd && !high_lane_select_n;
   wire [15:0] v = mem[cardAddr[3:0]];
   // no pull-ups: a released lane shows the inverse of the last value the card drove on it
   always @(negedge okL) lastV[7:0] = v[7:0];
   always @(negedge okH) lastV[15:8] = v[15:8];
   assign dataIn[7:0] = okL ? v[7:0] : dataOe[0] ? dataOut[7:0] : ~lastV[7:0];
   assign dataIn[15:8] = okH ? v[15:8] : dataOe[1] ? dataOut[15:8] : ~lastV[15:8];
   assign flash_ready_busy_n = !busy;
   assign #(0, 40) seated_detect_n = !ins;
   assign early_insert_detect_n = !ins;
   assign voltage_sense_first_n = 1'b1;
   assign voltage_sense_second_n = 1'b1;
endmodule

// ===== tb/fchb_host_tb.sv
// self-checking bench for the flash card host controller
module fchb_host_tb;
   timeunit 1ns;
   timeprecision 1ns;
   reg clk = 0, sys_rst = 1, reqValid = 0, reqWrite = 0, reqByte = 0, reqCardReset = 0;
   reg ins = 0, busy = 0;
   reg [25:0] reqAddr = 26'H0;
   reg [15:0] reqWdata = 16'H0, q, m;
   wire reqReady, rspValid, cardPresent, cardEarly, card5V, cardReady, outEnable_n;
   wire writeEnable_n, low_lane_select_n, high_lane_select_n, cardReset_n, narrow_host_flag_n;
   wire [24:0] cardAddr;
   wire [15:0] rspRdata, dataIn, dataOut;
   wire [1:0] dataOe;
   wire flash_ready_busy_n, seated_detect_n, early_insert_detect_n;
   wire voltage_sense_first_n, voltage_sense_second_n;
   integer miscompares = 0, num_checks = 0, cyc = 0, i, n;
   reg [59:0] rows [0:7];
   always #10 clk = ~clk;
   fchb_host #(.RST_CYC(2)) dut (.clk, .sys_rst, .reqValid, .reqReady, .reqWrite, .reqByte,
      .reqAddr, .reqWdata, .reqCardReset, .rspValid, .rspRdata, .cardPresent, .cardEarly,
      .card5V, .cardReady, .cardAddr, .outEnable_n, .writeEnable_n, .low_lane_select_n,
      .high_lane_select_n, .cardReset_n, .narrow_host_flag_n, .dataIn, .dataOut, .dataOe,
      .flash_ready_busy_n, .seated_detect_n, .early_insert_detect_n, .voltage_sense_first_n,
      .voltage_sense_second_n);
   fchb_card_model card (.ins, .busy, .cardReset_n, .outEnable_n, .writeEnable_n,
      .low_lane_select_n, .high_lane_select_n, .cardAddr, .dataOut, .dataOe, .dataIn,
      .flash_ready_busy_n, .seated_detect_n, .early_insert_detect_n,
      .voltage_sense_first_n, .voltage_sense_second_n);
   task chk(input [15:0] got, input [15:0] exp);
      num_checks = num_checks + 1;
      if (got !== exp) begin
         miscompares = miscompares + 1;
         $display("mismatch at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   task finish_test;
      $display("checks %0d mismatches %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   // caps the whole run at 2000 cycles; op gives up on a hung handshake after 60 cycles and runs on
   always @(posedge clk) begin
      cyc = cyc + 1;
      if (cyc == 2000) begin
         miscompares = miscompares + 1;
         finish_test;
      end
   end
   task op(input w, input b, input r, input [25:0] a, input [15:0] d);
      @(negedge clk);
      reqValid = !r;
      reqCardReset = r;
      reqWrite = w;
      reqByte = b;
      reqAddr = a;
      reqWdata = d;
      @(negedge clk);
      reqValid = 0;
      reqCardReset = 0;
      n = 0;
      while (rspValid !== 1'b1 && n < 60) begin
         @(negedge clk);
         n = n + 1;
      end
      chk({15'H0, rspValid}, 16'H1);
      q = rspRdata;
   endtask
   initial begin
      rows[0] = {2'b10, 26'H0000020, 16'H1234, 16'H0};
      rows[1] = {2'b00, 26'H0000020, 16'H0, 16'H1234};
      rows[2] = {2'b11, 26'H0000022, 16'H00A5, 16'H0};
      rows[3] = {2'b11, 26'H0000023, 16'H5A00, 16'H0};
      rows[4] = {2'b00, 26'H0000022, 16'H0, 16'H5AA5};
      rows[5] = {2'b01, 26'H0000021, 16'H0, 16'H1200};
      rows[6] = {2'b01, 26'H0000022, 16'H0, 16'H00A5};
      rows[7] = {2'b00, 26'H2000020, 16'H0, 16'H1234};
      repeat (6) @(negedge clk);
      sys_rst = 0;
      @(negedge clk);
      chk({outEnable_n, writeEnable_n, low_lane_select_n, high_lane_select_n, cardReset_n,
         narrow_host_flag_n, dataOe, reqReady}, 16'H01F9);
      chk({cardPresent, card5V}, 16'H1);
      ins = 1;
      repeat (10) @(negedge clk);
      chk({cardEarly, cardPresent, card5V}, 16'H7);
      $display("insertion test done");
      for (i = 0; i < 8; i = i + 1) begin
         op(rows[i][59], rows[i][58], 1'b0, rows[i][57:32], rows[i][31:16]);
         m = !rows[i][58] ? 16'HFFFF : rows[i][32] ? 16'HFF00 : 16'H00FF;
         if (!rows[i][59]) chk(q & m, rows[i][15:0] & m);
         $display("row %0d done", i);
      end
      op(1'b0, 1'b0, 1'b1, 26'H0, 16'H0);
      chk(cardReset_n, 16'H1);
      op(1'b0, 1'b0, 1'b0, 26'H0000020, 16'H0);
      chk(q, 16'H1234);
      $display("card reset test done");
      busy = 1;
      repeat (4) @(negedge clk);
      chk(cardReady, 16'H0);
      busy = 0;
      repeat (4) @(negedge clk);
      chk(cardReady, 16'H1);
      $display("busy test done");
      ins = 0;
      repeat (4) @(negedge clk);
      chk({cardEarly, cardPresent}, 16'H0);
      $display("removal test done");
      finish_test;
   end
endmodule
